// File: src/cts_tamper_ctrl.sv
// Purpose: Top of the case tamper sampling controller
// Assumes: 25 MHz mclk_i; switch output and button are asynchronous pins
// Notes:   Threshold divider hangs off sw_enable_o, so no extra pin drives it
`timescale 1ns/10ps
`include "cts_cfg.svh"
module cts_tamper_ctrl #(
  parameter int QTR_CYC   = `CTS_QTR_CYC,      // Cycles per quarter second
  parameter int ARM_SECS  = `CTS_ARM_SECONDS,  // Arming delay in seconds
  parameter int PULSE1    = `CTS_PULSE1_CYC,   // Pulse cycles, single coil
  parameter int PULSE2    = `CTS_PULSE2_CYC    // Pulse cycles, dual coil
) (
  input  wire logic              mclk_i,         // System clock
  input  wire logic              nrst_i,         // Async reset, active low
  input  wire logic              dual_coil_i,    // High selects dual-coil variant
  input  wire logic              switch_out_i,   // Switch output pin, high = open
  input  wire logic              clear_btn_n_i,  // Tamper clear button, active low
  input  wire logic [2:0]        primary_lvl_i,  // Primary supply level code
  input  wire logic [2:0]        backup_lvl_i,   // Backup two level code
  input  wire logic [2:0]        sys_lvl_i,      // Selected supply level code
  output logic                   sw_enable_o,    // Switch enable pulse
  output logic                   armed_o,        // Detection armed
  output logic                   tamper_now_o,   // Last sampled case state
  output logic                   tamper_latch_o, // First tamper latched
  output logic [31:0]            tamper_time_o,  // Seconds at first tamper
  output logic [31:0]            seconds_o,      // Seconds since reset
  output cts_pkg::cts_src_t      supply_src_o,   // Supply in use
  output logic                   supply_evt_o    // Supply switch event
);
  import cts_pkg::*;

  // Refuse a quarter second too short for the tick counter
  if (QTR_CYC < 2) begin : g_bad_qtr
    $error("cts_tamper_ctrl: QTR_CYC below 2");
  end

  // The synchronised reading must settle before the pulse ends
  if (PULSE1 < 3 || PULSE2 < 3) begin : g_bad_short
    $error("cts_tamper_ctrl: pulse below 3 cycles");
  end

  // A pulse must end before the next one is due
  if (PULSE1 >= 4 * QTR_CYC || PULSE2 >= 4 * QTR_CYC) begin : g_bad_long
    $error("cts_tamper_ctrl: pulse not shorter than one sample period");
  end

  // The arming delay counts whole seconds from zero
  if (ARM_SECS < 0) begin : g_bad_arm
    $error("cts_tamper_ctrl: negative arming delay");
  end

  // Internal state and strobes
  logic        rst_s1;
  logic        rst_n;
  logic [1:0]  sw_sync;
  logic [1:0]  btn_sync;
  logic [31:0] qtr_cnt;
  logic        qtr_tick;
  logic [3:0]  tick_cnt;
  logic [2:0]  sec_sub;
  logic [31:0] pulse_cnt;
  logic [31:0] pulse_len;
  logic        pulse_done;
  logic        start_pulse;
  logic        capture;
  logic        clear_req;
  cts_state_t  state;
  cts_state_t  next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Switch output synchroniser
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sw_sync <= 2'h0;
    end else begin
      sw_sync <= {sw_sync[0], switch_out_i};
    end
  end

  // Button synchroniser; idles released so reset shows no press
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      btn_sync <= 2'h3;
    end else begin
      btn_sync <= {btn_sync[0], clear_btn_n_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-second tick generator
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      qtr_cnt  <= 32'h0;
      qtr_tick <= 1'b0;
    end else if (qtr_cnt == 32'(QTR_CYC - 1)) begin
      qtr_cnt  <= 32'h0;
      qtr_tick <= 1'b1;
    end else begin
      qtr_cnt  <= qtr_cnt + 32'h1;
      qtr_tick <= 1'b0;
    end
  end

  // Tick counter wraps at 8, pulse starts at 4 and 8
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 4'h0;
    end else if (qtr_tick) begin
      tick_cnt <= (tick_cnt == `CTS_TICK_LAST) ? 4'h1 : tick_cnt + 4'h1;
    end
  end
  // Pulse request on the fourth and eighth tick
  assign start_pulse = qtr_tick && (tick_cnt == `CTS_TICK_FIRST - 4'h1 ||
                                    tick_cnt == `CTS_TICK_LAST - 4'h1);

  // Seconds since reset
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sec_sub   <= 3'h0;
      seconds_o <= 32'h0;
    end else if (qtr_tick) begin
      if (sec_sub == `CTS_TICKS_PER_SEC - 3'h1) begin
        sec_sub   <= 3'h0;
        seconds_o <= seconds_o + 32'h1;
      end else begin
        sec_sub <= sec_sub + 3'h1;
      end
    end
  end

  // Arming flag, sticky until the next reset
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      armed_o <= 1'b0;
    end else if (seconds_o >= 32'(ARM_SECS)) begin
      armed_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable pulse sequencer
  assign pulse_len  = dual_coil_i ? 32'(PULSE2) : 32'(PULSE1);
  assign pulse_done = (state == CTS_PULSE) && (pulse_cnt == pulse_len - 32'h1);

  // Next state: every fourth tick starts a pulse, the timer ends it
  always_comb begin
    case (state)
      CTS_IDLE:  next_state = start_pulse ? CTS_PULSE : CTS_IDLE;
      CTS_PULSE: next_state = pulse_done ? CTS_IDLE : CTS_PULSE;
      default:   next_state = CTS_IDLE;
    endcase
  end

  // State, pulse timer and enable register
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state       <= CTS_IDLE;
      pulse_cnt   <= 32'h0;
      sw_enable_o <= 1'b0;
    end else begin
      state       <= next_state;
      pulse_cnt   <= (state == CTS_PULSE && !pulse_done) ? pulse_cnt + 32'h1 : 32'h0;
      sw_enable_o <= (next_state == CTS_PULSE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output read at pulse end and tamper capture
  assign capture   = pulse_done && armed_o && sw_sync[1];
  assign clear_req = !btn_sync[1] && (supply_src_o == CTS_SRC_PRIMARY);

  // Case state seen at the end of each pulse
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tamper_now_o <= 1'b0;
    end else if (pulse_done) begin
      tamper_now_o <= armed_o && sw_sync[1];
    end
  end

  // Latch first event; a capture beats a simultaneous clear
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tamper_latch_o <= 1'b0;
    end else if (capture) begin
      tamper_latch_o <= 1'b1;
    end else if (clear_req) begin
      tamper_latch_o <= 1'b0;
    end
  end

  // Time of the first capture since the last clear
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tamper_time_o <= 32'h0;
    end else if (capture && !tamper_latch_o) begin
      tamper_time_o <= seconds_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply switching
  cts_supply_switch u_supply (
    .clk_i         (mclk_i),
    .rst_n_i       (rst_n),
    .primary_lvl_i (primary_lvl_i),
    .backup_lvl_i  (backup_lvl_i),
    .sys_lvl_i     (sys_lvl_i),
    .src_o         (supply_src_o),
    .switch_evt_o  (supply_evt_o)
  );
endmodule

// File: src/cts_cfg.svh
// Purpose: Constants for the case tamper sampling controller
// Assumes: 25 MHz clock on mclk_i
// Notes:   Times kept in their own units, cycle counts derived from them
//
// Summary of operation
// - Threshold voltage matters only while enabled; its absence when off is harmless.
// - Supply switching runs between primary and backup two; backup one excluded.
// - Below supervisor level 5, switch to the other supply only if it is OK.
// - Backup OK threshold is level 5, primary OK threshold is level 6.
// - Primary turning OK forces a return to primary; primary only.
// - Every supply switch raises a one-cycle event.
// - Tamper detection stays off until a set number of seconds after reset.
// - Time of the first tamper event is captured from the switch output.
// - Clear button while running on the primary supply clears the latch and re-arms capture.
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH

`define CTS_CLK_HZ            25000000
`define CTS_CLK_NS            40
`define CTS_QTR_SEC_MS        250
`define CTS_QTR_CYC           ((`CTS_CLK_HZ / 1000) * `CTS_QTR_SEC_MS)
`define CTS_PULSE1_MIN_NS     1003000
`define CTS_PULSE2_MIN_NS     1237000
`define CTS_PULSE_MARGIN_NS   20000
`define CTS_PULSE1_CYC       ((`CTS_PULSE1_MIN_NS + `CTS_PULSE_MARGIN_NS + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
`define CTS_PULSE2_CYC       ((`CTS_PULSE2_MIN_NS + `CTS_PULSE_MARGIN_NS + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
`define CTS_TICK_FIRST        4'h4
`define CTS_TICK_LAST         4'h8
`define CTS_TICKS_PER_SEC     3'h4
`define CTS_SVS_LEVEL         3'h5
`define CTS_BACKUP_OK_LEVEL   3'h5
`define CTS_PRIMARY_OK_LEVEL  3'h6
`define CTS_ARM_SECONDS       16'h001E

`endif

// File: src/cts_pkg.sv
// Purpose: Types for the case tamper sampling controller
// Assumes: Nothing
// Notes:   Constants live in cts_cfg.svh
package cts_pkg;
  typedef enum logic [1:0] {
    CTS_IDLE  = 2'b00,
    CTS_PULSE = 2'b01
  } cts_state_t;

  typedef enum logic [0:0] {
    CTS_SRC_PRIMARY = 1'b0,
    CTS_SRC_BACKUP  = 1'b1
  } cts_src_t;
endpackage

// File: src/cts_supply_switch.sv
// Purpose: Automatic selection between primary and backup two supplies
// Assumes: Levels arrive synchronised on mclk_i
// Notes:   Backup one never takes part in switching
`timescale 1ns/10ps
`include "cts_cfg.svh"
module cts_supply_switch (
  input  wire logic              clk_i,          // System clock
  input  wire logic              rst_n_i,        // Synchronised reset, active low
  input  wire logic [2:0]        primary_lvl_i,  // Primary supply level code
  input  wire logic [2:0]        backup_lvl_i,   // Backup two level code
  input  wire logic [2:0]        sys_lvl_i,      // Selected system supply level code
  output cts_pkg::cts_src_t      src_o,          // Supply in use
  output logic                   switch_evt_o    // One cycle on every switch
);
  import cts_pkg::*;

  logic primary_ok;
  logic backup_ok;
  logic primary_ok_d;
  logic sys_low;
  cts_src_t next_src;

  ////////////////////////////////////////////////////////////////////////////
  // Supply health
  assign primary_ok = (primary_lvl_i >= `CTS_PRIMARY_OK_LEVEL);
  assign backup_ok  = (backup_lvl_i >= `CTS_BACKUP_OK_LEVEL);
  assign sys_low    = (sys_lvl_i < `CTS_SVS_LEVEL);

  // Next source choice
  always_comb begin
    next_src = src_o;
    if (primary_ok && !primary_ok_d && src_o != CTS_SRC_PRIMARY) begin
      next_src = CTS_SRC_PRIMARY;
    end else if (sys_low) begin
      if (src_o == CTS_SRC_PRIMARY && backup_ok) begin
        next_src = CTS_SRC_BACKUP;
      end else if (src_o == CTS_SRC_BACKUP && primary_ok) begin
        next_src = CTS_SRC_PRIMARY;
      end
    end
  end

  // Source register and switch event
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_o        <= CTS_SRC_PRIMARY;
      primary_ok_d <= 1'b0;
      switch_evt_o <= 1'b0;
    end else begin
      src_o        <= next_src;
      primary_ok_d <= primary_ok;
      switch_evt_o <= (next_src != src_o);
    end
  end
endmodule

// File: testbench/cts_tamper_monitor.sv
// Purpose: Port assertions for the tamper controller
// Assumes: Bound into cts_tamper_ctrl
// Notes:   Counts follow the top parameters
`timescale 1ns/10ps
module cts_tamper_monitor #(
  parameter int QTR_CYC = 20,
  parameter int PULSE1  = 5,
  parameter int PULSE2  = 8
) (
  input wire logic              mclk_i,         // Clock
  input wire logic              nrst_i,         // Reset, active low
  input wire logic              dual_coil_i,    // Coil variant
  input wire logic [2:0]        primary_lvl_i,  // Primary level
  input wire logic [2:0]        backup_lvl_i,   // Backup level
  input wire logic [2:0]        sys_lvl_i,      // System level
  input wire logic              sw_enable_o,    // Enable
  input wire logic              armed_o,        // Armed
  input wire logic              tamper_now_o,   // Case state
  input wire logic              tamper_latch_o, // Latch
  input wire logic [31:0]       tamper_time_o,  // Capture time
  input wire logic [31:0]       seconds_o,      // Seconds
  input wire cts_pkg::cts_src_t supply_src_o,   // Supply
  input wire logic              supply_evt_o    // Event
);
  import cts_pkg::*;
  logic [31:0] hi_cnt;  // Cycles enable high
  logic [31:0] gap_cnt; // Cycles since rise
  logic        seen;    // A rise was seen
  // Pulse width and period counters
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_cnt <= '0;
      gap_cnt <= '0;
      seen <= 1'b0;
    end else begin
      hi_cnt <= sw_enable_o ? hi_cnt + 1 : '0;
      gap_cnt <= $rose(sw_enable_o) ? 32'h1 : gap_cnt + 1;
      seen <= seen | $rose(sw_enable_o);
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_pri_low;
    supply_src_o == CTS_SRC_PRIMARY && sys_lvl_i < 3'h5 && primary_lvl_i < 3'h6;
  endsequence
  a_pulse_width: assert property ($fell(sw_enable_o) |->
    hi_cnt == (dual_coil_i ? PULSE2 : PULSE1)) else $error("pulse width wrong");
  a_sample_period: assert property ($rose(sw_enable_o) && seen |->
    gap_cnt == 4 * QTR_CYC) else $error("sample period wrong");
  a_now_at_end: assert property ($changed(tamper_now_o) |-> $fell(sw_enable_o))
    else $error("case state moved outside pulse end");
  a_quiet_unarmed: assert property (!armed_o |-> !tamper_latch_o && !tamper_now_o)
    else $error("detection active while unarmed");
  a_armed_sticky: assert property (armed_o |=> armed_o) else $error("armed dropped");
  a_time_held: assert property (tamper_latch_o && $past(tamper_latch_o) |->
    $stable(tamper_time_o)) else $error("capture time moved");
  a_time_capture: assert property ($rose(tamper_latch_o) |->
    tamper_time_o == seconds_o) else $error("capture time not seconds");
  a_event_switch: assert property (supply_evt_o == $changed(supply_src_o))
    else $error("event and switch disagree");
  a_to_backup: assert property (s_pri_low ##0 backup_lvl_i >= 3'h5 |=>
    supply_src_o == CTS_SRC_BACKUP) else $error("no switch to backup");
  a_hold_primary: assert property (s_pri_low ##0 backup_lvl_i < 3'h5 |=>
    supply_src_o == CTS_SRC_PRIMARY) else $error("switched to low backup");
  a_primary_return: assert property (primary_lvl_i >= 3'h6 && $past(primary_lvl_i) < 3'h6
    |=> supply_src_o == CTS_SRC_PRIMARY) else $error("no return to primary");
endmodule
bind cts_tamper_ctrl cts_tamper_monitor #(.QTR_CYC(QTR_CYC), .PULSE1(PULSE1),
  .PULSE2(PULSE2)) u_mon (.mclk_i, .nrst_i, .dual_coil_i, .primary_lvl_i,
  .backup_lvl_i, .sys_lvl_i, .sw_enable_o, .armed_o, .tamper_now_o, .tamper_latch_o,
  .tamper_time_o, .seconds_o, .supply_src_o, .supply_evt_o);

// File: testbench/cts_switch_model.sv
// Purpose: Behavioural inductive proximity switch
// Assumes: Threshold divider hangs off the enable
// Notes:   Output is meaningless while disabled, so it shows the inverse
`timescale 1ns/10ps
module cts_switch_model (
  input  wire logic clk_i,       // Clock
  input  wire logic enable_i,    // Enable drive
  input  wire logic case_open_i, // Target away
  output logic      out_o        // Switch output
);
  logic thr_ok;        // Threshold voltage present
  logic last = 1'b0;   // Last valid output
  // Divider is powered from the enable only
  assign thr_ok = enable_i;
  // Remember the last valid reading
  always_ff @(posedge clk_i) begin
    if (thr_ok) begin
      last <= case_open_i;
    end
  end
  assign out_o = thr_ok ? case_open_i : ~last;
endmodule

// File: testbench/tb.sv
// Purpose: Self-checking bench for the tamper controller
// Assumes: Short counts: 20-cycle quarter, 2 s arming, pulses 5 and 8
// Notes:   Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/10ps
module tb;
  import cts_pkg::*;
  logic        mclk_i = 1'b0;             // Clock
  logic        nrst_i = 1'b0;             // Reset
  logic        dual_coil_i = 1'b0;        // Coil variant
  logic        case_open = 1'b1;          // Case state
  logic        switch_out_i;              // Switch output
  logic        clear_btn_n_i = 1'b1;      // Clear button
  logic [2:0]  primary_lvl_i = 3'h7;      // Primary level
  logic [2:0]  backup_lvl_i = 3'h7;       // Backup level
  logic [2:0]  sys_lvl_i = 3'h7;          // System level
  logic        sw_enable_o;               // Enable
  logic        armed_o;                   // Armed
  logic        tamper_now_o;              // Case state
  logic        tamper_latch_o;            // Latch
  logic [31:0] tamper_time_o;             // Capture time
  logic [31:0] seconds_o;                 // Seconds
  cts_src_t    supply_src_o;              // Supply
  logic        supply_evt_o;              // Event
  int          bad_count = 0;             // Mismatches
  int          checked = 0;               // Comparisons
  always #20 mclk_i = ~mclk_i;
  cts_tamper_ctrl #(.QTR_CYC(20), .ARM_SECS(2), .PULSE1(5), .PULSE2(8)) dut (.mclk_i,
    .nrst_i, .dual_coil_i, .switch_out_i, .clear_btn_n_i, .primary_lvl_i, .backup_lvl_i,
    .sys_lvl_i, .sw_enable_o, .armed_o, .tamper_now_o, .tamper_latch_o, .tamper_time_o,
    .seconds_o, .supply_src_o, .supply_evt_o);
  cts_switch_model u_sw (.clk_i(mclk_i), .enable_i(sw_enable_o), .case_open_i(case_open),
    .out_o(switch_out_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (sw_enable_o !== v && n < 400) begin
      @(negedge mclk_i);
      n++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  // Case open before arming leaves nothing latched
  task automatic t_arm();
    int n;
    n = 0;
    while (armed_o !== 1'b1 && n < 400) begin
      @(negedge mclk_i);
      n++;
    end
    chk("armed", 1, armed_o);
    chk("seconds at arm", 2, seconds_o);
    chk("latch before arm", 0, tamper_latch_o);
  endtask
  // First open captured, later pulses keep the time
  task automatic t_capture();
    int n;
    logic [31:0] tim;
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    chk("latch", 1, tamper_latch_o);
    chk("case now", 1, tamper_now_o);
    chk("first time", 2, tamper_time_o);
    tim = tamper_time_o;
    @(posedge mclk_i) case_open <= 1'b0;
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    chk("case closed", 0, tamper_now_o);
    chk("time held", tim, tamper_time_o);
  endtask
  // Pulse width per variant and rise-to-rise period
  task automatic t_pulse(input logic d, input int len);
    int n;
    int hi;
    int lo;
    wait_lvl(1'b0, n);
    @(posedge mclk_i) dual_coil_i <= d;
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
    chk("pulse width", len, hi);
    chk("period", 80, hi + lo);
  endtask
  // Supply switching, events and the clear button
  task automatic t_supply();
    int n;
    @(posedge mclk_i) primary_lvl_i <= 3'h5;
    sys_lvl_i <= 3'h4;
    backup_lvl_i <= 3'h4;
    step(3);
    chk("stay primary", CTS_SRC_PRIMARY, supply_src_o);
    @(posedge mclk_i) backup_lvl_i <= 3'h5;
    step(1);
    chk("to backup", CTS_SRC_BACKUP, supply_src_o);
    chk("event", 1, supply_evt_o);
    @(posedge mclk_i) clear_btn_n_i <= 1'b0;
    step(5);
    chk("clear refused", 1, tamper_latch_o);
    @(posedge mclk_i) primary_lvl_i <= 3'h6;
    sys_lvl_i <= 3'h7;
    step(1);
    chk("return", CTS_SRC_PRIMARY, supply_src_o);
    chk("event back", 1, supply_evt_o);
    step(5);
    chk("cleared", 0, tamper_latch_o);
    wait_lvl(1'b0, n);
    @(posedge mclk_i) clear_btn_n_i <= 1'b1;
    case_open <= 1'b1;
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    chk("re-armed latch", 1, tamper_latch_o);
    chk("new capture time", seconds_o, tamper_time_o);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_arm();
    t_capture();
    t_pulse(1'b0, 5);
    t_pulse(1'b1, 8);
    t_supply();
    conclude();
  end
  initial begin
    #240000;
    bad_count++;
    conclude();
  end
endmodule
